// ==== verilog/spdif_pkg.sv ====
// Constants, register map and carrier types of the consumer digital audio transmitter
`default_nettype none
package spdif_pkg;
	localparam int          CLK_HZ        = 125_000_000;
	localparam int          SETTLE_US     = 125;
	localparam int          SETTLE_CYCLES = SETTLE_US * (CLK_HZ / 1_000_000);
	localparam int          MIN_CLK_HALF  = 4;
	localparam int          NUM_SOURCES   = 4;

	localparam logic [11:0] TX_CONTROL_ADDR = 12'h5c2;
	localparam logic [11:0] CS_FIRST_ADDR   = 12'h5c3;
	localparam logic [11:0] CS_SECOND_ADDR  = 12'h5c4;
	localparam logic [11:0] CS_THIRD_ADDR   = 12'h5c5;
	localparam logic [11:0] SOURCE_ADDR     = 12'h5c6;
	localparam logic [11:0] VOLUME_ADDR     = 12'h5c7;
	localparam logic [11:0] RATE_ADDR       = 12'h5c8;
	localparam logic [11:0] EVENT_ADDR      = 12'h5c9;
	localparam logic [11:0] MASK_ADDR       = 12'h5ca;
	localparam logic [11:0] PATH_STS_ADDR   = 12'h5cb;

	localparam int          ENABLE_BIT  = 0;
	localparam int          VALID_A_BIT = 12;
	localparam int          VALID_B_BIT = 13;
	localparam logic [15:0] CTRL_MASK   = 16'h3001;
	localparam logic [15:0] CS3_MASK    = 16'h0fff;
	localparam logic [15:0] CS2_RESET   = 16'h0b01;
	localparam logic [15:0] VOL_RESET   = 16'h8080;
	localparam logic [7:0]  SYSTEM_CLOCK_RESET = 8'h7d;
	localparam logic [3:0]  RATE_RESET  = 4'h2;

	localparam int EV_ENABLE_FAIL = 0;
	localparam int EV_RATE_REFUSE = 1;
	localparam int EV_BLOCK_START = 2;

	localparam logic [7:0] PRE_B = 8'he8;
	localparam logic [7:0] PRE_M = 8'he2;
	localparam logic [7:0] PRE_W = 8'he4;
	localparam logic [7:0] LAST_FRAME = 8'hbf;

	typedef struct packed {
		logic [31:0] sample;
		logic        narrow;
	} source_t;

	typedef struct packed {
		logic [15:0] tx_control;
		logic [15:0] cs_first;
		logic [15:0] cs_second;
		logic [15:0] cs_third;
		logic [7:0]  source_sel;
		logic [15:0] volume;
		logic [3:0]  rate;
		logic [7:0]  system_clock_mhz;
		logic [2:0]  events;
		logic [2:0]  mask;
		logic [15:0] settle;
		logic        running;
		logic [31:0] nco;
		logic [6:0]  half;
		logic [7:0]  frame;
		logic        line;
		logic        pre;
		logic        parity;
		logic [31:0] samp_a;
		logic [31:0] samp_b;
		logic [15:0] rdata;
		logic        irq;
	} state_t;

	function automatic logic [31:0] rate_hz(input logic [3:0] code);
		case (code)
			4'h0:    rate_hz = 32'd32000;
			4'h1:    rate_hz = 32'd44100;
			4'h3:    rate_hz = 32'd88200;
			4'h4:    rate_hz = 32'd96000;
			4'h5:    rate_hz = 32'd176400;
			4'h6:    rate_hz = 32'd192000;
			default: rate_hz = 32'd48000;
		endcase
	endfunction

	// Phase step for 128 half-cells per frame
	function automatic logic [31:0] nco_step(input logic [3:0] code);
		nco_step = 32'(((64'(rate_hz(code)) * 64'd128) << 32) / 64'(CLK_HZ));
	endfunction
endpackage
`default_nettype wire

// ==== verilog/spdif_output_generator.sv ====
// Consumer digital audio transmitter with register port and volume-scaled sources
`timescale 1ns/100ps
`default_nettype none
module spdif_output_generator #(
	parameter int SETTLE = spdif_pkg::SETTLE_CYCLES
) (
	input  wire logic                                     i_sys_clk,
	input  wire logic                                     i_reset,
	input  wire logic [11:0]                              i_addr,
	input  wire logic [15:0]                              i_wdata,
	input  wire logic                                     i_wr,
	input  wire logic                                     i_rd,
	input  wire spdif_pkg::source_t [spdif_pkg::NUM_SOURCES-1:0] i_sources,
	output logic      [15:0]                              o_rdata,
	output logic                                          o_spdif,
	output logic                                          o_irq
);
	spdif_pkg::state_t q;
	spdif_pkg::state_t d;
	logic [1:0][31:0]  scaled;
	logic [1:0]        path_ok;
	logic [32:0]       nco_sum;
	logic [4:0]        slot;
	logic              sub_b;
	logic              bitv;
	logic              pre;
	logic              clock_ok;
	logic              start;
	logic [2:0]        ev_set;
	logic [31:0]       cur;
	logic [5:0]        didx;
	logic [7:0]        pat;
	logic [2:0]        pidx;

	// Per-channel source pick, 24-bit cut of narrow sources and volume; unity gain is 0x80
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		logic [3:0]         sel;
		logic [31:0]        raw;
		logic signed [40:0] prod;
		logic signed [40:0] shifted;
		always_comb
		begin
			sel = q.source_sel[ch*4 +: 4];
			raw = 32'h00000000;
			path_ok[ch] = (sel != 4'h0) && (sel <= 4'(spdif_pkg::NUM_SOURCES));
			if (path_ok[ch])
			begin
				raw = i_sources[2'(sel - 4'h1)].sample;
				if (i_sources[2'(sel - 4'h1)].narrow)
					raw[7:0] = 8'h00;
			end
			prod = 41'(signed'(raw)) * 41'(signed'({1'b0, q.volume[ch*8 +: 8]}));
			shifted = prod >>> 7;
			if (shifted > 41'sh0007fffffff)
				scaled[ch] = 32'h7fffffff;
			else if (shifted < -41'sh00080000000)
				scaled[ch] = 32'h80000000;
			else
				scaled[ch] = shifted[31:0];
		end
	end

	function automatic logic status_bit(input spdif_pkg::state_t s, input logic b);
		logic [39:0] v;
		v = {s.cs_third[11:0], s.cs_second[15:12],
			b ? s.cs_second[11:8] : s.cs_second[7:4], s.cs_second[3:0], s.cs_first};
		status_bit = (s.frame < 8'd40) ? v[6'(s.frame)] : 1'b0;
	endfunction

	always_comb
	begin
		d = q;
		d.rdata = 16'h0000;
		ev_set = 3'h0;
		start = 1'b0;
		clock_ok = (32'(q.system_clock_mhz) * 32'd1_000_000)
			>= (spdif_pkg::rate_hz(q.rate) * 32'(128 * spdif_pkg::MIN_CLK_HALF));

		// Rate writes only settle after sources have stayed cleared long enough
		if (q.source_sel != 8'h00)
			d.settle = 16'h0000;
		else if (q.settle < 16'(SETTLE))
			d.settle = q.settle + 16'h0001;

		if (i_wr)
		begin
			case (i_addr)
				spdif_pkg::TX_CONTROL_ADDR:
				begin
					d.tx_control = i_wdata & spdif_pkg::CTRL_MASK;
					if (!i_wdata[spdif_pkg::ENABLE_BIT])
						d.running = 1'b0;
					else if (!q.running && clock_ok)
						start = 1'b1;
					else if (!q.running)
						ev_set[spdif_pkg::EV_ENABLE_FAIL] = 1'b1;
				end
				spdif_pkg::CS_FIRST_ADDR:  d.cs_first = i_wdata;
				spdif_pkg::CS_SECOND_ADDR: d.cs_second = i_wdata;
				spdif_pkg::CS_THIRD_ADDR:  d.cs_third = i_wdata & spdif_pkg::CS3_MASK;
				spdif_pkg::SOURCE_ADDR:    d.source_sel = i_wdata[7:0];
				spdif_pkg::VOLUME_ADDR:    d.volume = i_wdata;
				spdif_pkg::RATE_ADDR:
				begin
					d.system_clock_mhz = i_wdata[15:8];
					// A rate change is refused unless sources have stayed cleared for SETTLE cycles; running is not checked
					if (i_wdata[3:0] != q.rate)
					begin
						if (q.source_sel == 8'h00 && q.settle >= 16'(SETTLE))
							d.rate = i_wdata[3:0];
						else
							ev_set[spdif_pkg::EV_RATE_REFUSE] = 1'b1;
					end
				end
				spdif_pkg::EVENT_ADDR:     d.events = q.events & ~i_wdata[2:0];
				spdif_pkg::MASK_ADDR:      d.mask = i_wdata[2:0];
				default:
				begin
				end
			endcase
		end

		if (i_rd)
		begin
			case (i_addr)
				spdif_pkg::TX_CONTROL_ADDR: d.rdata = q.tx_control;
				spdif_pkg::CS_FIRST_ADDR:   d.rdata = q.cs_first;
				spdif_pkg::CS_SECOND_ADDR:  d.rdata = q.cs_second;
				spdif_pkg::CS_THIRD_ADDR:   d.rdata = q.cs_third;
				spdif_pkg::SOURCE_ADDR:     d.rdata = {8'h00, q.source_sel};
				spdif_pkg::VOLUME_ADDR:     d.rdata = q.volume;
				spdif_pkg::RATE_ADDR:       d.rdata = {q.system_clock_mhz, 4'h0, q.rate};
				spdif_pkg::EVENT_ADDR:      d.rdata = {13'h0000, q.events};
				spdif_pkg::MASK_ADDR:       d.rdata = {13'h0000, q.mask};
				spdif_pkg::PATH_STS_ADDR:
					d.rdata = {13'h0000, q.running, q.running & path_ok[1],
						q.running & path_ok[0]};
				default:                    d.rdata = 16'h0000;
			endcase
		end

		sub_b = q.half[6];
		slot = q.half[5:1];
		pre = (q.half[5:0] == 6'h00) ? q.line : q.pre;
		cur = sub_b ? q.samp_b : q.samp_a;
		didx = 6'(slot) + 6'd4;
		pidx = 3'd7 - {slot[1:0], q.half[0]};
		if (sub_b)
			pat = spdif_pkg::PRE_W;
		else if (q.frame == 8'h00)
			pat = spdif_pkg::PRE_B;
		else
			pat = spdif_pkg::PRE_M;
		case (slot)
			5'd28:   bitv = sub_b ? q.tx_control[spdif_pkg::VALID_B_BIT]
				: q.tx_control[spdif_pkg::VALID_A_BIT];
			5'd29:   bitv = 1'b0;
			5'd30:   bitv = status_bit(q, sub_b);
			5'd31:   bitv = q.parity;
			default: bitv = cur[didx[4:0]];
		endcase
		nco_sum = {1'b0, q.nco} + {1'b0, spdif_pkg::nco_step(q.rate)};

		if (start)
		begin
			// Output goes to the pin, and q.line is also read back by the core for the next cell and the preamble polarity
			d.running = 1'b1;
			d.nco = 32'h00000000;
			d.half = 7'h00;
			d.frame = 8'h00;
			d.line = 1'b0;
			d.samp_a = scaled[0];
			d.samp_b = scaled[1];
			ev_set[spdif_pkg::EV_BLOCK_START] = 1'b1;
		end
		else if (!q.running)
		begin
			d.nco = 32'h00000000;
			d.half = 7'h00;
			d.frame = 8'h00;
			d.line = 1'b0;
		end
		else
		begin
			d.nco = nco_sum[31:0];
			if (nco_sum[32])
			begin
				d.pre = pre;
				if (slot < 5'd4)
					d.line = pat[pidx] ^ pre;
				else if (!q.half[0])
					d.line = ~q.line;
				else
					d.line = bitv ? ~q.line : q.line;
				if (!q.half[0])
				begin
					if (slot == 5'd4)
						d.parity = bitv;
					else if (slot < 5'd31)
						d.parity = q.parity ^ bitv;
				end
				d.half = q.half + 7'h01;
				if (q.half == 7'h7f)
				begin
					d.samp_a = scaled[0];
					d.samp_b = scaled[1];
					if (q.frame == spdif_pkg::LAST_FRAME)
					begin
						d.frame = 8'h00;
						ev_set[spdif_pkg::EV_BLOCK_START] = 1'b1;
					end
					else
						d.frame = q.frame + 8'h01;
				end
			end
		end

		// A new event beats a clear in the same cycle
		d.events = d.events | ev_set;
		d.irq = |(d.events & d.mask);
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			q <= '0;
			q.cs_second <= spdif_pkg::CS2_RESET;
			q.volume <= spdif_pkg::VOL_RESET;
			q.rate <= spdif_pkg::RATE_RESET;
			q.system_clock_mhz <= spdif_pkg::SYSTEM_CLOCK_RESET;
			q.settle <= 16'(SETTLE);
		end
		else
			q <= d;
	end

	assign o_rdata = q.rdata;
	assign o_spdif = q.line;
	assign o_irq = q.irq;
endmodule
`default_nettype wire

// ==== dv/spdif_rx_model.sv ====
// Receiver model on the serial pin: counts transitions and the longest coded run
`timescale 1ns/100ps
`default_nettype none
module spdif_rx_model (
	input  wire logic i_clk,
	input  wire logic i_line,
	output int        o_edges,
	output int        o_max_run
);
	logic last_q = 1'b0;
	int   run_q  = 0;
	initial
	begin
		o_edges = 0;
		o_max_run = 0;
	end
	// Runs over 64 clocks are an idle line, not coding, so they are not recorded
	always @(posedge i_clk)
	begin
		last_q <= i_line;
		run_q <= (i_line != last_q) ? 0 : run_q + 1;
		if (i_line != last_q)
		begin
			o_edges <= o_edges + 1;
			if (run_q < 64 && run_q + 1 > o_max_run)
				o_max_run <= run_q + 1;
		end
	end
endmodule
`default_nettype wire

// ==== dv/spdif_chk.sv ====
// Assertions on the register port and serial pin of the transmitter
`timescale 1ns/100ps
`default_nettype none
module spdif_chk (
	input wire logic        i_sys_clk,
	input wire logic        i_reset,
	input wire logic [11:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        o_spdif,
	input wire logic        o_irq
);
	logic [15:0] ctrl_q;
	logic [15:0] cs2_q;
	logic [2:0]  mask_q;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			ctrl_q <= 16'h0;
			cs2_q <= spdif_pkg::CS2_RESET;
			mask_q <= 3'h0;
		end
		else if (i_wr)
		begin
			if (i_addr == spdif_pkg::TX_CONTROL_ADDR)
				ctrl_q <= i_wdata & spdif_pkg::CTRL_MASK;
			if (i_addr == spdif_pkg::CS_SECOND_ADDR)
				cs2_q <= i_wdata;
			if (i_addr == spdif_pkg::MASK_ADDR)
				mask_q <= i_wdata[2:0];
		end
	end
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0)
		else $error("read data not idle");
	a_ctrl_readback: assert property (i_rd && i_addr == spdif_pkg::TX_CONTROL_ADDR
		|=> o_rdata == ctrl_q) else $error("control readback wrong");
	a_cs2_readback: assert property (i_rd && i_addr == spdif_pkg::CS_SECOND_ADDR
		|=> o_rdata == cs2_q) else $error("second status readback wrong");
	a_cs3_upper: assert property (i_rd && i_addr == spdif_pkg::CS_THIRD_ADDR
		|=> o_rdata[15:12] == 4'h0) else $error("third status upper bits set");
	a_unmapped_zero: assert property (i_rd && (i_addr < 12'h5c2 || i_addr > 12'h5cb)
		|=> o_rdata == 16'h0) else $error("unmapped read not zero");
	a_idle_low: assert property (!ctrl_q[0] [*3] |-> !o_spdif)
		else $error("pin moves while disabled");
	a_irq_masked: assert property (mask_q == 3'h0 [*2] |-> !o_irq)
		else $error("interrupt with all masked");
	a_cell_hold: assert property (disable iff (i_reset || !ctrl_q[0])
		$changed(o_spdif) |=> $stable(o_spdif) [*3]) else $error("half cell too short");
endmodule
bind spdif_output_generator spdif_chk chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_spdif(o_spdif), .o_irq(o_irq));
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the transmitter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        i_sys_clk = 1'b0;
	logic        i_reset   = 1'b1;
	logic [11:0] i_addr    = 12'h0;
	logic [15:0] i_wdata   = 16'h0;
	logic        i_wr      = 1'b0;
	logic        i_rd      = 1'b0;
	spdif_pkg::source_t [spdif_pkg::NUM_SOURCES-1:0] i_sources = '0;
	logic [15:0] o_rdata;
	logic        o_spdif;
	logic        o_irq;
	logic [31:0] seed = 32'h7ec1ec89;
	logic [15:0] v;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          edges;
	int          max_run;
	int          k;
	always #4 i_sys_clk = ~i_sys_clk;
	spdif_output_generator #(.SETTLE(8)) uut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_sources(i_sources),
		.o_rdata(o_rdata), .o_spdif(o_spdif), .o_irq(o_irq));
	spdif_rx_model rx (.i_clk(i_sys_clk), .i_line(o_spdif), .o_edges(edges),
		.o_max_run(max_run));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Register readback as the rules define it: masked fields read zero
	function automatic logic [15:0] reg_expect(input logic [11:0] a, input logic [15:0] d);
		case (a)
			spdif_pkg::CS_THIRD_ADDR: reg_expect = d & spdif_pkg::CS3_MASK;
			spdif_pkg::SOURCE_ADDR:   reg_expect = {8'h00, d[7:0]};
			default:                  reg_expect = d;
		endcase
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		chk($sformatf("rdata at %h", a), e, o_rdata);
	endtask
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Samples keep changing so every latched frame carries fresh data
	always @(posedge i_sys_clk)
		for (int i = 0; i < spdif_pkg::NUM_SOURCES; i++)
			i_sources[i] <= {xs(), seed[3]};
	initial
	begin
		repeat (100000) @(posedge i_sys_clk);
		error_cnt++;
		print_verdict();
	end
	initial
	begin
		repeat (2) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		rd(12'h5c2, 16'h0);
		rd(12'h5c3, 16'h0);
		rd(12'h5c4, 16'h0b01);
		rd(12'h5c5, 16'h0);
		rd(12'h5c7, 16'h8080);
		rd(12'h5c8, 16'h7d02);
		rd(12'h5cc, 16'h0);
		for (int i = 0; i < 15; i++)
		begin
			v = 16'(xs());
			wr(12'h5c3 + 12'(i % 5), v);
			rd(12'h5c3 + 12'(i % 5), reg_expect(12'h5c3 + 12'(i % 5), v));
		end
		// Unity gain again, so the serial data below stays busy
		wr(12'h5c7, spdif_pkg::VOL_RESET);
		wr(12'h5c6, 16'h0021);
		wr(12'h5c8, 16'h7d06);
		rd(12'h5c8, 16'h7d02);
		rd(12'h5c9, 16'h0002);
		wr(12'h5c9, 16'h0002);
		wr(12'h5c6, 16'h0000);
		repeat (10) @(posedge i_sys_clk);
		wr(12'h5c8, 16'h7d06);
		rd(12'h5c8, 16'h7d06);
		wr(12'h5c8, 16'h0106);
		wr(12'h5c2, 16'h1001);
		rd(12'h5cb, 16'h0000);
		rd(12'h5c9, 16'h0001);
		wr(12'h5c2, 16'h0000);
		wr(12'h5c8, 16'h7d06);
		wr(12'h5c9, 16'h0007);
		wr(12'h5ca, 16'h0007);
		wr(12'h5c6, 16'h0021);
		wr(12'h5c2, 16'h3001);
		for (k = 0; k < 50 && o_irq !== 1'b1; k++)
			@(posedge i_sys_clk);
		chk("o_irq on block start", 16'h1, {15'h0, o_irq});
		rd(12'h5c9, 16'h0004);
		rd(12'h5cb, 16'h0007);
		wr(12'h5c9, 16'h0004);
		repeat (2) @(posedge i_sys_clk);
		chk("o_irq after clear", 16'h0, {15'h0, o_irq});
		repeat (3000) @(posedge i_sys_clk);
		chk("edge count", 16'h1, {15'h0, edges > 400});
		chk("longest run", 16'h1, {15'h0, max_run >= 13 && max_run <= 17});
		// Code 0 and codes above four leave their path silent
		wr(12'h5c6, 16'h0050);
		rd(12'h5cb, 16'h0004);
		wr(12'h5c2, 16'h0000);
		repeat (4) @(posedge i_sys_clk);
		chk("o_spdif idle", 16'h0, {15'h0, o_spdif});
		print_verdict();
	end
endmodule
`default_nettype wire
